// file: common/sppd_pkg.sv
/*
  Package of the three-phase, six-output PWM generator: register offsets, field positions,
  reset values, mode codes and the control carrier type.
  Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
*/
package sppd_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CNT_W   = 16;
  localparam int DT_W    = 10;
  localparam int NPHASE  = 3;
  localparam int NPIN    = 6;
  localparam int PRE_W   = 7;
  localparam int SEL_W   = 3;
  localparam int ADDR_W  = 8;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL_A   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL_B   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MODE     = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PORT     = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_DEAD     = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_DCMP0    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PCMP     = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_DBUF0    = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_PBUF     = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_COUNT    = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h38;
  localparam logic [ADDR_W-1:0] WORD_STEP    = 8'h04;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTA_CE_BIT   = 0;
  localparam int CTA_DIRECT_COMPARE_WRITE_ENABLE_BIT = 1;
  localparam int CTA_B3_BIT   = 2;
  localparam int CTA_SEL_LSB  = 3;
  localparam int CTB_DTE_BIT  = 0;
  localparam int MODE_LSB     = 0;
  localparam int MODE_ALV_BIT = 2;
  localparam int ST_DOWN_BIT  = 0;
  localparam int ST_FIRST_BIT = 1;
  localparam int ST_FF_LSB    = 2;

  // ----------------------------------------------------------------
  // Mode codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_SYM  = 2'h0;
  localparam logic [1:0] MODE_ASYM = 2'h1;
  localparam logic [1:0] MODE_SAW  = 2'h2;

  localparam logic [CNT_W-1:0] CNT_ZERO  = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE   = 16'h0001;
  localparam logic [CNT_W-1:0] PCMP_RST  = 16'hFFFF;
  localparam logic [CNT_W-1:0] CMP_RST   = 16'h0000;
  localparam logic [DT_W-1:0]  DT_RST    = 10'h000;
  localparam logic [DT_W-1:0]  DT_ZERO   = 10'h000;
  localparam logic [DT_W-1:0]  DT_ONE    = 10'h001;
  localparam logic [PRE_W-1:0] PRE_ONE   = 7'h01;
  localparam logic [1:0]       HTRANS_NS = 2'h2;

  typedef struct packed {
    logic [SEL_W-1:0] clk_sel;
    logic             period_xfer;
    logic             direct_wr;
    logic             count_en;
  } sppd_ctrl_t;

  localparam sppd_ctrl_t CTRL_RST = '0;

endpackage

// file: verif/sppd_gate_drv.sv
/*
  Gate driver model of the inverter: counts active cycles per pin in a window
  and flags both switches of a leg being on. Assumes one hclk domain.
*/
`timescale 1ns/1ns
module sppd_gate_drv
  import sppd_pkg::*;
(
  input  wire logic            hclk,
  input  wire logic [NPIN-1:0] pin,
  input  wire logic [NPIN-1:0] oe,
  input  wire logic            alv,
  input  wire logic            clr,
  input  wire logic            win,
  output int                   act_cnt [NPIN],
  output logic                 shoot
);
  logic [NPIN-1:0] drv;
  // A pin whose enable is low floats, so it never turns a switch on
  assign drv = oe & (pin ~^ {NPIN{alv}});
  always @(posedge hclk)
  begin
    for (int i = 0; i < NPIN; i++)
      act_cnt[i] <= clr ? 0 : act_cnt[i] + int'(win && drv[i]);
    shoot <= !clr && (shoot || |(drv & (drv >> 1) & 6'h15));
  end
endmodule

// file: verif/sppd_pwm_chk.sv
/*
  Port checker of the PWM generator: bus response, pin enables, overlap, dead gap, idle.
  Assumes one hclk domain; control bits are shadowed from observed bus writes.
*/
`timescale 1ns/1ns
module sppd_pwm_chk
  import sppd_pkg::*;
(
  input wire logic            hclk,
  input wire logic            hresetn,
  input wire logic            hsel,
  input wire logic [31:0]     haddr,
  input wire logic [1:0]      htrans,
  input wire logic            hwrite,
  input wire logic [2:0]      hsize,
  input wire logic [31:0]     hwdata,
  input wire logic            hready,
  input wire logic            hreadyout,
  input wire logic            hresp,
  input wire logic [31:0]     hrdata,
  input wire logic [NPIN-1:0] phase_out,
  input wire logic [NPIN-1:0] phase_oe,
  input wire logic            underflow_event,
  input wire logic            period_match_event
);
  // ------
  // Shadow
  // ------
  logic              wr_ff, ce_ff, alv_ff, dte_ff;
  logic [ADDR_W-1:0] wa_ff;
  logic [NPIN-1:0]   oe_ff, act;
  logic [1:0]        off_ff;
  logic [2:0]        pos_act, neg_act;
  assign act     = phase_out ~^ {NPIN{alv_ff}};
  assign pos_act = {act[4], act[2], act[0]};
  assign neg_act = {act[5], act[3], act[1]};
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      {wr_ff, wa_ff, oe_ff, ce_ff, alv_ff, dte_ff, off_ff} <= '0;
    else
    begin
      wr_ff <= hready && hsel && hwrite && (htrans == HTRANS_NS);
      if (hready) wa_ff <= haddr[ADDR_W-1:0];
      if (wr_ff && wa_ff == OFS_PORT) oe_ff <= hwdata[NPIN-1:0];
      if (wr_ff && wa_ff == OFS_CTRL_A) ce_ff <= hwdata[CTA_CE_BIT];
      if (wr_ff && wa_ff == OFS_MODE) alv_ff <= hwdata[MODE_ALV_BIT];
      if (wr_ff && wa_ff == OFS_CTRL_B) dte_ff <= hwdata[CTB_DTE_BIT];
      // Three idle cycles cover the flop and pin registers settling
      off_ff <= ce_ff ? 2'h0 : off_ff + 2'(off_ff != 2'h3);
    end
  end
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_rd_hole;
    hsel && hready && !hwrite && (htrans == HTRANS_NS) && (haddr[ADDR_W-1:0] > OFS_STATUS);
  endsequence
  sequence s_pm_once;
    period_match_event ##1 !period_match_event;
  endsequence
  sequence s_uf_once;
    underflow_event ##1 !underflow_event;
  endsequence
  property p_okay; hreadyout && !hresp; endproperty
  property p_oe; phase_oe == oe_ff; endproperty
  property p_overlap; (pos_act & neg_act) == 3'h0; endproperty
  property p_dead_gap; dte_ff |-> (pos_act & ~$past(pos_act) & $past(neg_act)) == 3'h0; endproperty
  property p_idle; off_ff == 2'h3 |-> pos_act == 3'h0; endproperty
  property p_quiet; off_ff == 2'h3 |-> !underflow_event && !period_match_event; endproperty
  property p_hole; s_rd_hole |=> hrdata == 32'h0; endproperty
  property p_pm_pulse; period_match_event |-> s_pm_once; endproperty
  property p_uf_pulse; underflow_event |-> s_uf_once; endproperty
  property p_evt_excl; !(underflow_event && period_match_event); endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or not okay");
  a_oe: assert property (p_oe) else $error("pin enables differ from port bits");
  a_overlap: assert property (p_overlap) else $error("both pins of a leg active");
  a_dead_gap: assert property (p_dead_gap) else $error("activation without gap");
  a_idle: assert property (p_idle) else $error("positive pin active while stopped");
  a_quiet: assert property (p_quiet) else $error("event while stopped");
  a_hole: assert property (p_hole) else $error("unmapped read not zero");
  a_pm_pulse: assert property (p_pm_pulse) else $error("period event too long");
  a_uf_pulse: assert property (p_uf_pulse) else $error("underflow event too long");
  a_evt_excl: assert property (p_evt_excl) else $error("both events at once");
endmodule
bind sppd_pwm sppd_pwm_chk i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .phase_out(phase_out), .phase_oe(phase_oe),
  .underflow_event(underflow_event), .period_match_event(period_match_event));

// file: verif/tb.sv
/*
  Bench of the PWM generator: bus tasks, integer width model, sweep of modes and levels.
  Assumes the gate driver model and the bound checker; one hclk domain.
*/
`timescale 1ns/1ns
module tb
  import sppd_pkg::*;
;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        hready, hreadyout, hresp, uf_ev, pm_ev, shoot;
  logic        alv = 1'b0, clr = 1'b0, win = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [5:0]  phase_out, phase_oe;
  int          act_cnt [NPIN];
  int          num_errors = 0, n_checks = 0, seed = 32'h70582372, pm_n = 0, uf_n = 0, sc, t;
  assign hready = hreadyout;
  sppd_pwm i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .phase_out(phase_out), .phase_oe(phase_oe),
    .underflow_event(uf_ev), .period_match_event(pm_ev));
  sppd_gate_drv i_drv (.hclk(hclk), .pin(phase_out), .oe(phase_oe), .alv(alv), .clr(clr),
    .win(win), .act_cnt(act_cnt), .shoot(shoot));
  initial
  begin
    forever #20 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    pm_n <= clr ? 0 : pm_n + int'(win && pm_ev);
    uf_n <= clr ? 0 : uf_n + int'(win && uf_ev);
  end
  // -----
  // Tasks
  // -----
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NS;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] v;
    bus(1'b1, a, wd, v);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    chk(nm, v, exp);
  endtask
  function automatic int rnd(input int n);
    return int'($unsigned($random(seed)) % n);
  endfunction
  // Active clocks of one pin over three periods; a leg that never toggles keeps no dead time
  function automatic int exp_w(input int saw, input int p, input int dv, input int pos);
    int per, f, w;
    per = saw ? p + 1 : 2 * p;
    if (saw) f = (dv > p) ? per : (dv == p) ? 0 : dv + 1;
    else f = (dv == 0) ? per : (dv >= p) ? 0 : 2 * (p - dv);
    if (pos == 0) f = per - f;
    if (f == per || f == 0) return 3 * f * sc;
    w = f * sc - t;
    return 3 * ((w > 0) ? w : 0);
  endfunction
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ---------
  // Main flow
  // ---------
  initial
  begin
    int p, per, xfer, saw, sel, dt;
    int d [3];
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("oe_reset", {26'h0, phase_oe}, 32'h0);
    rdc("pcmp_reset", OFS_PCMP, {16'h0, PCMP_RST});
    rdc("unmapped", 8'h3C, 32'h0);
    wr(OFS_DBUF0, 32'h5);
    wr(OFS_CTRL_A, 32'(1 << CTA_DIRECT_COMPARE_WRITE_ENABLE_BIT));
    wr(OFS_DCMP0, 32'h9);
    rdc("dcmp_direct", OFS_DCMP0, 32'h9);
    wr(OFS_CTRL_A, 32'h0);
    wr(OFS_DCMP0, 32'h9);
    rdc("dcmp_copy", OFS_DCMP0, 32'h5);
    wr(OFS_PORT, 32'h3F);
    @(negedge hclk);
    chk("oe_on", {26'h0, phase_oe}, 32'h3F);
    chk("idle_start", {26'h0, phase_out}, 32'h15);
    @(posedge hclk);
    for (int i = 0; i < 12; i++)
    begin
      saw = int'(i % 3 == 2);
      alv = 1'(i / 3 % 2);
      sel = rnd(3);
      sc = 1 << sel;
      dt = rnd(4);
      t = (i >= 6) ? dt + 1 : 0;
      p = 8 + rnd(24);
      xfer = rnd(2);
      per = saw ? p + 1 : 2 * p;
      for (int g = 0; g < 3; g++) d[g] = rnd(p + 2);
      d[0] = (i % 4 == 0) ? 0 : (i % 4 == 1) ? p : (i % 4 == 2) ? p + 1 : d[0];
      wr(OFS_CTRL_A, 32'h0);
      wr(OFS_MODE, {29'h0, alv, 2'(i % 3)});
      wr(OFS_CTRL_B, (i >= 6) ? 32'h1 : 32'h0);
      wr(OFS_DEAD, 32'(dt));
      wr(OFS_PCMP, 32'(xfer ? p + 3 : p));
      wr(OFS_PBUF, 32'(xfer ? p : p + 3));
      for (int g = 0; g < 3; g++)
      begin
        wr(OFS_DBUF0 + 8'(4 * g), 32'(d[g]));
        wr(OFS_DCMP0 + 8'(4 * g), 32'h0);
      end
      wr(OFS_CTRL_A, 32'((sel << CTA_SEL_LSB) | (xfer << CTA_B3_BIT) | 1));
      repeat (p * sc - 2) @(posedge hclk);
      @(negedge hclk);
      if (saw) chk("saw_first", {26'h0, phase_out}, alv ? 32'h2A : 32'h15);
      repeat (6 * (p + 3) * sc + 24) @(posedge hclk);
      clr <= 1'b1;
      @(posedge hclk);
      clr <= 1'b0;
      win <= 1'b1;
      repeat (3 * per * sc) @(posedge hclk);
      win <= 1'b0;
      @(posedge hclk);
      for (int g = 0; g < 3; g++)
      begin
        chk("pos_width", act_cnt[2 * g], exp_w(saw, p, d[g], 1));
        chk("neg_width", act_cnt[2 * g + 1], exp_w(saw, p, d[g], 0));
      end
      chk("period_events", pm_n, 3);
      chk("underflow_events", uf_n, saw ? 0 : 3);
      chk("overlap", {31'h0, shoot}, 32'h0);
      rdc("period_cmp", OFS_PCMP, 32'(p));
      wr(OFS_CTRL_A, 32'h0);
      repeat (t + 6) @(posedge hclk);
      @(negedge hclk);
      chk("idle_pins", {26'h0, phase_out}, alv ? 32'h2A : 32'h15);
      @(posedge hclk);
    end
    end_of_test();
  end
  initial
  begin
    repeat (60000) @(posedge hclk);
    num_errors++;
    end_of_test();
  end
endmodule

// file: verilog/sppd_dead_time.sv
/*
  One phase pair of the dead-time stage: turns a phase flip-flop into the
  positive and negative activity of its two pins, delaying every activation while run and dt_en are high.
  Assumes the phase flip-flop is on hclk and the setting is stable while used.
*/
`timescale 1ns/1ns
module sppd_dead_time
  import sppd_pkg::*;
(
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic            run,
  input  wire logic            dt_en,
  input  wire logic [DT_W-1:0] dt_set,
  input  wire logic            phase_ff,
  output logic                 pos_act_ff,
  output logic                 neg_act_ff
);

  logic            prev_ff;
  logic [DT_W-1:0] dt_cnt_ff;
  logic            busy_ff;
  logic            edge_seen;
  logic            block;

  assign edge_seen = phase_ff ^ prev_ff;
  // Block from the change for setting plus one clocks
  assign block = dt_en & (edge_seen | (busy_ff & (dt_cnt_ff != DT_ZERO)));

  // ----------------------------------------------------------------
  // Dead-time counter
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev_ff   <= 1'b0;
      dt_cnt_ff <= DT_RST;
      busy_ff   <= 1'b0;
    end
    else if (!run)
    begin
      prev_ff   <= 1'b0;
      dt_cnt_ff <= DT_RST;
      busy_ff   <= 1'b0;
    end
    else
    begin
      prev_ff <= phase_ff;
      if (edge_seen && dt_en)
      begin
        dt_cnt_ff <= dt_set;
        busy_ff   <= 1'b1;
      end
      else if (busy_ff)
      begin
        // Stops instead of wrapping below zero
        if (dt_cnt_ff == DT_ZERO)
          busy_ff <= 1'b0;
        else
          dt_cnt_ff <= dt_cnt_ff - DT_ONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin activity; both sides share one register delay
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pos_act_ff <= 1'b0;
      neg_act_ff <= 1'b0;
    end
    else
    begin
      pos_act_ff <= phase_ff & ~block;
      neg_act_ff <= ~phase_ff & ~block;
    end
  end

endmodule

// file: verilog/sppd_pwm.sv
/*
  Six-output three-phase PWM generator with dead time, AHB-Lite register slave.
  Covers symmetric and asymmetric triangular modes and the sawtooth mode.
  Assumes a single hclk domain and a host that keeps the software obligations.
*/
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ns
module sppd_pwm
  import sppd_pkg::*;
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  output logic [NPIN-1:0]        phase_out,
  output logic [NPIN-1:0]        phase_oe,
  output logic                   underflow_event,
  output logic                   period_match_event
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sppd_ctrl_t             ctrl_ff;
  logic                   dt_en_ff;
  logic [1:0]             mode_ff;
  logic                   alv_high_ff;
  logic [NPIN-1:0]        port_fn_ff;
  logic [DT_W-1:0]        dead_time_ff;
  logic [CNT_W-1:0]       duty_cmp_ff [NPHASE];
  logic [CNT_W-1:0]       duty_buf_ff [NPHASE];
  logic [CNT_W-1:0]       period_cmp_ff;
  logic [CNT_W-1:0]       period_buf_ff;
  logic [CNT_W-1:0]       counter_ff;
  logic                   down_ff;
  logic                   first_ff;
  logic [NPHASE-1:0]      phase_ff;
  logic [PRE_W-1:0]       pre_ff;
  logic                   wr_ph_ff;
  logic [ADDR_W-1:0]      addr_ph_ff;
  logic [31:0]            rdata_ff;
  logic                   addr_take;
  logic                   tick;
  logic                   at_period;
  logic                   at_zero;
  logic                   saw;
  logic                   pm_hit;
  logic                   uf_hit;
  logic                   duty_xfer;
  logic                   period_xfer;
  logic                   eff_down;
  logic [NPHASE-1:0]      pos_act;
  logic [NPHASE-1:0]      neg_act;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [PRE_W-1:0] pre_mask(input logic [SEL_W-1:0] sel);
    pre_mask = PRE_W'((1 << sel) - 1);
  endfunction

  function automatic logic word_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] base,
                                    input int unsigned       idx);
    word_hit = (a == ADDR_W'(base + ADDR_W'(idx) * WORD_STEP));
  endfunction

  // ----------------------------------------------------------------
  // Bus slave: zero wait states, always OKAY
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_ff;
  assign addr_take = hsel & hready & (htrans == HTRANS_NS);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ph_ff   <= 1'b0;
      addr_ph_ff <= '0;
    end
    else
    begin
      wr_ph_ff   <= addr_take & hwrite;
      addr_ph_ff <= haddr[ADDR_W-1:0];
    end
  end

  // Read data is sampled in the address phase; counter is that cycle's value
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rdata_ff <= '0;
    else if (addr_take && !hwrite)
    begin
      rdata_ff <= '0;
      unique case (haddr[ADDR_W-1:0])
        OFS_CTRL_A: rdata_ff[CTA_SEL_LSB+SEL_W-1:0] <= ctrl_ff;
        OFS_CTRL_B: rdata_ff[CTB_DTE_BIT]           <= dt_en_ff;
        OFS_MODE:   rdata_ff[MODE_ALV_BIT:MODE_LSB] <= {alv_high_ff, mode_ff};
        OFS_PORT:   rdata_ff[NPIN-1:0]              <= port_fn_ff;
        OFS_DEAD:   rdata_ff[DT_W-1:0]              <= dead_time_ff;
        OFS_PCMP:   rdata_ff[CNT_W-1:0]             <= period_cmp_ff;
        OFS_PBUF:   rdata_ff[CNT_W-1:0]             <= period_buf_ff;
        OFS_COUNT:  rdata_ff[CNT_W-1:0]             <= counter_ff;
        OFS_STATUS: rdata_ff[ST_FF_LSB+NPHASE-1:0]  <= {phase_ff, first_ff, down_ff};
        default:
        begin
          for (int i = 0; i < NPHASE; i++)
          begin
            if (word_hit(haddr[ADDR_W-1:0], OFS_DCMP0, i))
              rdata_ff[CNT_W-1:0] <= duty_cmp_ff[i];
            if (word_hit(haddr[ADDR_W-1:0], OFS_DBUF0, i))
              rdata_ff[CNT_W-1:0] <= duty_buf_ff[i];
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_ff      <= CTRL_RST;
      dt_en_ff     <= 1'b0;
      mode_ff      <= MODE_SYM;
      alv_high_ff  <= 1'b0;
      port_fn_ff   <= '0;
      dead_time_ff <= DT_RST;
    end
    else if (wr_ph_ff)
    begin
      unique case (addr_ph_ff)
        OFS_CTRL_A: ctrl_ff      <= hwdata[CTA_SEL_LSB+SEL_W-1:0];
        OFS_CTRL_B: dt_en_ff     <= hwdata[CTB_DTE_BIT];
        OFS_MODE:
        begin
          mode_ff     <= hwdata[MODE_LSB+1:MODE_LSB];
          alv_high_ff <= hwdata[MODE_ALV_BIT];
        end
        OFS_PORT:   port_fn_ff   <= hwdata[NPIN-1:0];
        OFS_DEAD:   dead_time_ff <= hwdata[DT_W-1:0];
        default:    ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Count clock prescaler
  // ----------------------------------------------------------------
  assign tick = ctrl_ff.count_en && ((pre_ff & pre_mask(ctrl_ff.clk_sel)) == pre_mask(ctrl_ff.clk_sel));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pre_ff <= '0;
    else if (!ctrl_ff.count_en || tick)
      pre_ff <= '0;
    else
      pre_ff <= pre_ff + PRE_ONE;
  end

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  assign saw       = (mode_ff == MODE_SAW);
  assign at_period = (counter_ff == period_cmp_ff);
  assign at_zero   = (counter_ff == CNT_ZERO);
  assign pm_hit    = tick & (saw | ~down_ff) & at_period;
  assign uf_hit    = tick & ~saw & down_ff & at_zero;
  // Symmetric mode ignores the period-match transfer
  assign duty_xfer   = uf_hit | (pm_hit & (mode_ff != MODE_SYM));
  assign period_xfer = ctrl_ff.period_xfer & (saw ? pm_hit : uf_hit);
  // Period match counts as down, underflow as up
  assign eff_down  = down_ff ? ~at_zero : at_period;

  assign underflow_event    = uf_hit;
  assign period_match_event = pm_hit;

  // ----------------------------------------------------------------
  // Main counter
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      counter_ff <= CNT_ZERO;
      down_ff    <= 1'b0;
    end
    else if (!ctrl_ff.count_en)
    begin
      counter_ff <= CNT_ZERO;
      down_ff    <= 1'b0;
    end
    else if (tick)
    begin
      if (saw)
      begin
        down_ff    <= 1'b0;
        counter_ff <= pm_hit ? CNT_ZERO : counter_ff + CNT_ONE;
      end
      else if (pm_hit)
      begin
        down_ff    <= 1'b1;
        counter_ff <= counter_ff - CNT_ONE;
      end
      else if (uf_hit)
      begin
        down_ff    <= 1'b0;
        counter_ff <= CNT_ONE;
      end
      else
        counter_ff <= down_ff ? counter_ff - CNT_ONE : counter_ff + CNT_ONE;
    end
  end

  // ----------------------------------------------------------------
  // Period compare and buffer; hardware transfer wins over a write
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      period_cmp_ff <= PCMP_RST;
      period_buf_ff <= PCMP_RST;
    end
    else
    begin
      if (period_xfer)
        period_cmp_ff <= period_buf_ff;
      else if (wr_ph_ff && addr_ph_ff == OFS_PCMP)
        period_cmp_ff <= hwdata[CNT_W-1:0];
      if (wr_ph_ff && addr_ph_ff == OFS_PBUF)
        period_buf_ff <= hwdata[CNT_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Per-phase compare, buffer, flip-flop and dead-time stage
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      first_ff <= 1'b1;
    else if (!ctrl_ff.count_en)
      first_ff <= 1'b1;
    else if (pm_hit)
      first_ff <= 1'b0;
  end

  for (genvar g = 0; g < NPHASE; g++)
  begin : g_phase
    logic [CNT_W-1:0] eff_cmp;
    logic             match;
    logic             dwr;
    logic             bwr;

    // A transfer compares against the value it brings in, the same cycle
    assign eff_cmp = duty_xfer ? duty_buf_ff[g] : duty_cmp_ff[g];
    assign match   = tick & (counter_ff == eff_cmp);
    assign dwr     = wr_ph_ff & word_hit(addr_ph_ff, OFS_DCMP0, g);
    assign bwr     = wr_ph_ff & word_hit(addr_ph_ff, OFS_DBUF0, g);

    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        duty_cmp_ff[g] <= CMP_RST;
        duty_buf_ff[g] <= CMP_RST;
      end
      else
      begin
        if (duty_xfer)
          duty_cmp_ff[g] <= duty_buf_ff[g];
        else if (dwr)
          // Without direct write, a write only pulls in the buffer
          duty_cmp_ff[g] <= ctrl_ff.direct_wr ? hwdata[CNT_W-1:0] : duty_buf_ff[g];
        if (bwr)
          duty_buf_ff[g] <= hwdata[CNT_W-1:0];
      end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
        phase_ff[g] <= 1'b0;
      else if (!ctrl_ff.count_en)
        phase_ff[g] <= 1'b0;
      else if (saw)
      begin
        if (first_ff && !pm_hit)
          phase_ff[g] <= 1'b0;
        else if (match)
          phase_ff[g] <= 1'b0;
        else if (pm_hit)
          phase_ff[g] <= 1'b1;
      end
      else if (match)
        phase_ff[g] <= ~eff_down;
    end

    sppd_dead_time u_dead
    (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .run        (ctrl_ff.count_en),
      .dt_en      (dt_en_ff),
      .dt_set     (dead_time_ff),
      .phase_ff   (phase_ff[g]),
      .pos_act_ff (pos_act[g]),
      .neg_act_ff (neg_act[g])
    );

    // Even pins carry the positive phase, odd pins the negative
    assign phase_out[2*g]   = pos_act[g] ~^ alv_high_ff;
    assign phase_out[2*g+1] = neg_act[g] ~^ alv_high_ff;
  end

  // Pins float until their port function bit is set
  assign phase_oe = port_fn_ff;

endmodule
